// ### common/pmem_pkg.sv
// shared constants and types for the program memory map and protection block
package pmem_pkg;
   localparam int unsigned FLASH_BYTES = 16384;  // whole code flash
   localparam int unsigned PAGE_BYTES  = 128;    // erase granule
   localparam int unsigned KBYTE       = 1024;
   localparam int unsigned SEC_BYTES   = 128;    // secure code region
   localparam int unsigned IRAM_BYTES  = 256;    // internal scratch ram
   localparam int unsigned EXTENDED_DATA_RAM_BYTES  = 1024;   // extended data ram
   localparam logic [15:0] RESET_VECTOR = 16'h0000;
   localparam logic [15:0] VEC_FIRST    = 16'h0003;
   localparam logic [15:0] VEC_SPACING  = 16'h0008;
   localparam logic [15:0] SEC_BASE     = 16'hff80;
   localparam logic [6:0]  SEC_LAST_IDX = 7'h7f;
   localparam logic [7:0]  CFG_RESET    = 8'hff;  // factory state of config
   localparam logic [7:0]  ERASED       = 8'hff;
   localparam logic [7:0]  CONCEALED    = 8'h00;
   localparam logic [7:0]  SEC_OPEN     = 8'hff;  // last byte: non-secured
   localparam int unsigned LOADER_SIZE_SELECT_LSB   = 0;
   localparam logic [2:0]  LOADER_SIZE_SELECT_NONE  = 3'b111;
   localparam logic [2:0]  LOADER_SIZE_SELECT_1K    = 3'b110;
   localparam logic [2:0]  LOADER_SIZE_SELECT_2K    = 3'b101;
   localparam logic [2:0]  LOADER_SIZE_SELECT_3K    = 3'b100;
   localparam logic [14:0] PAGE_MASK    = 15'h7f80;
   localparam logic [14:0] PAGE_LAST    = 15'h007f;
   localparam logic [14:0] FLASH_LAST   = 15'h3fff;

   typedef enum logic [1:0] {
      OP_READ, OP_PROGRAM, OP_ERASE, OP_CHIP_ERASE
   } cmd_op_t;
   typedef enum logic [1:0] {TGT_FLASH, TGT_SECURE, TGT_CONFIG} target_t;
   typedef enum logic {ST_IDLE, ST_ERASE} state_t;

   typedef struct packed {
      logic        valid;
      logic [15:0] addr;
   } code_req_t;
   typedef struct packed {
      logic        valid;
      logic        write;
      logic        ext;      // 1: extended ram, 0: internal ram
      logic [9:0]  addr;
      logic [7:0]  wdata;
   } dmem_req_t;
   typedef struct packed {
      logic        valid;
      cmd_op_t     op;
      target_t     target;
      logic        in_system_programming;      // 1: external programming, 0: cpu code
      logic [15:0] addr;
      logic [7:0]  wdata;
   } cmd_req_t;
   typedef struct packed {
      logic        ack;
      logic [7:0]  data;
   } rd_rsp_t;
   typedef struct packed {
      logic        done;
      logic        fail;
      logic [7:0]  rdata;
   } cmd_rsp_t;
endpackage : pmem_pkg

// ### logic/program_memory_map_protect.sv
// program flash map, loader remap, secure region protection and data rams
`timescale 1ns/1ps

// Operation
// - after any reset fetch starts at logical address zero of boot region
// - interrupt entries fixed at 0003H plus eight bytes per source
// - loader boot remaps program counter zero to the loader start
// - loader size field splits 16K flash into loader and application
// - loader size config byte resets to all ones, meaning no loader
// - flash is organised and erased in 128-byte pages
// - flash controller offers erase, program and read operations
// - separate data space: 256 bytes internal plus 1K extended ram
// - application region serves fetch and code-memory data reads
// - application may reprogram loader; loader may update app and config
// - any application or loader page may hold non-volatile data
// - secure region FF80H-FFFFH, untouched by whole-chip erase
// - last secure byte 0xFF means non-secured, anything else secured
// - non-secured region is readable, erasable and programmable freely
// - secured data reads give 00H unless executing inside the region
// - secured fetches give zero while the debug port is connected
// - secured region refuses programming commands to program, read, erase
// - boot select bit picks application (1) or loader (0) boot at reset release; SW_BOOT_LOADER picks on software reset
module program_memory_map_protect (
   input  wire logic                CLK,
   input  wire logic                RST_N,
   input  wire logic                BOOT_REGION_SELECT,
   input  wire logic                SW_RESET,
   input  wire logic                SW_BOOT_LOADER,
   input  wire logic                DEBUG_CONNECTED,
   input  wire logic                INT_TAKE,
   input  wire logic [4:0]          INT_NUM,
   input  wire pmem_pkg::code_req_t FETCH_REQ,
   input  wire pmem_pkg::code_req_t CODE_READ_REQ,
   input  wire pmem_pkg::dmem_req_t DMEM_REQ,
   input  wire pmem_pkg::cmd_req_t  CMD_REQ,
   output logic [15:0]              VECTOR_ADDR,
   output logic [14:0]              BOOT_BASE,
   output logic                     BOOT_LOADER,
   output logic                     SECURED,
   output logic [7:0]               LOADER_SIZE_CONFIG,
   output pmem_pkg::rd_rsp_t        FETCH_RSP,
   output pmem_pkg::rd_rsp_t        CODE_READ_RSP,
   output pmem_pkg::rd_rsp_t        DMEM_RSP,
   output pmem_pkg::cmd_rsp_t       CMD_RSP,
   output logic                     CMD_BUSY
);
   import pmem_pkg::*;

   typedef struct packed {
      state_t      st;
      logic        booted;
      logic        boot_ldr;
      logic [7:0]  ldcfg;
      logic [7:0]  sec_last;
      logic        exec_sec;
      logic [14:0] ptr;
      logic [14:0] stop;
      target_t     etgt;
      logic [15:0] vector;
      logic [14:0] base;
      rd_rsp_t     fetch;
      rd_rsp_t     cread;
      rd_rsp_t     dmem;
      cmd_rsp_t    cmd;
      logic        secured;
      logic        busy;
   } pmem_state_t;

   pmem_state_t state_reg;
   pmem_state_t state_next;

   logic [7:0]  flash_mem [FLASH_BYTES];
   logic [7:0]  sec_mem   [SEC_BYTES];
   logic [7:0]  iram_mem  [IRAM_BYTES];
   logic [7:0]  extended_data_ram_mem  [EXTENDED_DATA_RAM_BYTES];

   logic        flash_we;
   logic [13:0] flash_wa;
   logic [7:0]  flash_wd;
   logic        sec_we;
   logic [6:0]  sec_wa;
   logic [7:0]  sec_wd;

   ////////////////////////////////////////////////////////////////////////
   // helper functions

   // loader size in bytes from the 3-bit select; 0xx all mean 4K
   function automatic logic [14:0] loader_bytes(input logic [2:0] sel);
      logic [14:0] kb;
      kb = 15'd0;
      if (sel == LOADER_SIZE_SELECT_NONE) begin
         kb = 15'd0;
      end else if (sel == LOADER_SIZE_SELECT_1K) begin
         kb = 15'd1;
      end else if (sel == LOADER_SIZE_SELECT_2K) begin
         kb = 15'd2;
      end else if (sel == LOADER_SIZE_SELECT_3K) begin
         kb = 15'd3;
      end else begin
         kb = 15'd4;
      end
      return 15'(kb * KBYTE);
   endfunction : loader_bytes

   // loader starts right where the application region ends
   function automatic logic [14:0] loader_start(input logic [2:0] sel);
      return 15'(FLASH_BYTES) - loader_bytes(sel);
   endfunction : loader_start

   // logical code address to physical flash address
   function automatic logic [13:0] code_phys(input logic [15:0] a,
                                             input logic        ldr,
                                             input logic [2:0]  sel);
      logic [14:0] p;
      p = a[14:0];
      if (ldr && (a[14:0] < loader_bytes(sel)) && a[15] == 1'b0) begin
         p = 15'(loader_start(sel) + a[14:0]);
      end
      return p[13:0];
   endfunction : code_phys

   function automatic logic in_secure(input logic [15:0] a);
      return a >= SEC_BASE;
   endfunction : in_secure

   function automatic logic in_flash(input logic [15:0] a);
      return a < 16'(FLASH_BYTES);
   endfunction : in_flash

   ////////////////////////////////////////////////////////////////////////
   // next-state logic

   // one process owns every control decision except the data ram write enables; arrays are written below
   always_comb begin
      logic [2:0]  sel;
      logic        sec_on;
      logic        ok;
      logic [13:0] pa;
      sel        = state_reg.ldcfg[LOADER_SIZE_SELECT_LSB +: 3];
      sec_on     = state_reg.sec_last != SEC_OPEN;
      ok         = 1'b0;
      pa         = 14'd0;
      state_next = state_reg;
      flash_we   = 1'b0;
      flash_wa   = 14'd0;
      flash_wd   = ERASED;
      sec_we     = 1'b0;
      sec_wa     = 7'd0;
      sec_wd     = ERASED;
      state_next.fetch.ack = 1'b0;
      state_next.cread.ack = 1'b0;
      state_next.dmem.ack  = 1'b0;
      state_next.cmd.done  = 1'b0;
      state_next.cmd.fail  = 1'b0;

      // boot region caught once after reset release, or on software reset
      if (!state_reg.booted) begin
         state_next.booted   = 1'b1;
         state_next.boot_ldr = !BOOT_REGION_SELECT &&
                               (sel != LOADER_SIZE_SELECT_NONE);
      end else if (SW_RESET) begin
         state_next.boot_ldr = SW_BOOT_LOADER && (sel != LOADER_SIZE_SELECT_NONE);
      end
      // interrupt entry, relative to the booted region's own zero
      if (INT_TAKE) begin
         state_next.vector = 16'(VEC_FIRST + VEC_SPACING * INT_NUM);
      end

      // instruction fetch
      if (FETCH_REQ.valid) begin
         state_next.fetch.ack = 1'b1;
         state_next.exec_sec  = in_secure(FETCH_REQ.addr);
         if (in_secure(FETCH_REQ.addr)) begin
            state_next.fetch.data = (sec_on && DEBUG_CONNECTED) ?
               CONCEALED : sec_mem[FETCH_REQ.addr[6:0]];
         end else if (in_flash(FETCH_REQ.addr)) begin
            pa = code_phys(FETCH_REQ.addr, state_reg.boot_ldr, sel);
            state_next.fetch.data = flash_mem[pa];
         end else begin
            state_next.fetch.data = ERASED;
         end
      end

      // code-memory data read; concealed unless running in the region
      if (CODE_READ_REQ.valid) begin
         state_next.cread.ack = 1'b1;
         if (in_secure(CODE_READ_REQ.addr)) begin
            state_next.cread.data = (sec_on && !state_reg.exec_sec) ?
               CONCEALED : sec_mem[CODE_READ_REQ.addr[6:0]];
         end else if (in_flash(CODE_READ_REQ.addr)) begin
            pa = code_phys(CODE_READ_REQ.addr, state_reg.boot_ldr, sel);
            state_next.cread.data = flash_mem[pa];
         end else begin
            state_next.cread.data = ERASED;
         end
      end

      // data space is separate from code; read data for reads only
      if (DMEM_REQ.valid) begin
         state_next.dmem.ack = 1'b1;
         if (!DMEM_REQ.write) begin
            state_next.dmem.data = DMEM_REQ.ext ? extended_data_ram_mem[DMEM_REQ.addr]
                                   : iram_mem[DMEM_REQ.addr[7:0]];
         end
      end

      case (state_reg.st)
         ST_IDLE: begin
            if (CMD_REQ.valid) begin
               // permission: config reads from anywhere, writes only from loader code or external
               // programming; the secure region only while open
               if (CMD_REQ.op == OP_CHIP_ERASE) begin
                  ok = CMD_REQ.in_system_programming;
               end else if (CMD_REQ.target == TGT_SECURE) begin
                  ok = !sec_on;
               end else if (CMD_REQ.target == TGT_CONFIG) begin
                  ok = CMD_REQ.op == OP_READ || CMD_REQ.in_system_programming ||
                       state_reg.boot_ldr;
               end else begin
                  ok = in_flash(CMD_REQ.addr);
               end
               if (!ok) begin
                  state_next.cmd.done = 1'b1;
                  state_next.cmd.fail = 1'b1;
               end else begin
                  case (CMD_REQ.op)
                     OP_READ: begin
                        state_next.cmd.done  = 1'b1;
                        state_next.cmd.rdata =
                           (CMD_REQ.target == TGT_CONFIG) ? state_reg.ldcfg :
                           (CMD_REQ.target == TGT_SECURE) ?
                              sec_mem[CMD_REQ.addr[6:0]] :
                              flash_mem[CMD_REQ.addr[13:0]];
                     end
                     OP_PROGRAM: begin
                        // programming can only clear bits
                        state_next.cmd.done = 1'b1;
                        if (CMD_REQ.target == TGT_CONFIG) begin
                           state_next.ldcfg = state_reg.ldcfg & CMD_REQ.wdata;
                        end else if (CMD_REQ.target == TGT_SECURE) begin
                           sec_we = 1'b1;
                           sec_wa = CMD_REQ.addr[6:0];
                           sec_wd = sec_mem[sec_wa] & CMD_REQ.wdata;
                           if (sec_wa == SEC_LAST_IDX) begin
                              state_next.sec_last = sec_wd;
                           end
                        end else begin
                           flash_we = 1'b1;
                           flash_wa = CMD_REQ.addr[13:0];
                           flash_wd = flash_mem[flash_wa] & CMD_REQ.wdata;
                        end
                     end
                     OP_ERASE: begin
                        if (CMD_REQ.target == TGT_CONFIG) begin
                           state_next.cmd.done = 1'b1;
                           state_next.ldcfg    = CFG_RESET;
                        end else begin
                           // one byte per cycle over the whole page
                           state_next.st   = ST_ERASE;
                           state_next.etgt = CMD_REQ.target;
                           state_next.ptr  = CMD_REQ.addr[14:0] & PAGE_MASK;
                           state_next.stop = (CMD_REQ.addr[14:0] & PAGE_MASK)
                                             | PAGE_LAST;
                        end
                     end
                     default: begin
                        // whole flash and config; secure region left alone
                        state_next.st   = ST_ERASE;
                        state_next.etgt = TGT_CONFIG;
                        state_next.ptr  = 15'd0;
                        state_next.stop = FLASH_LAST;
                     end
                  endcase
               end
            end
         end
         ST_ERASE: begin
            if (state_reg.etgt == TGT_SECURE) begin
               sec_we = 1'b1;
               sec_wa = state_reg.ptr[6:0];
            end else begin
               flash_we = 1'b1;
               flash_wa = state_reg.ptr[13:0];
            end
            state_next.ptr = 15'(state_reg.ptr + 15'd1);
            if (state_reg.ptr == state_reg.stop) begin
               state_next.st       = ST_IDLE;
               state_next.cmd.done = 1'b1;
               if (state_reg.etgt == TGT_SECURE) begin
                  state_next.sec_last = ERASED;
               end else if (state_reg.etgt == TGT_CONFIG) begin
                  state_next.ldcfg = CFG_RESET;  // chip erase clears config
               end
            end
         end
         default: begin
            state_next.st = ST_IDLE;
         end
      endcase

      // logical zero maps to flash 0 or to the loader start; taken from
      // the next config so a size change never leaves a stale base
      state_next.base = state_next.boot_ldr ?
         loader_start(state_next.ldcfg[LOADER_SIZE_SELECT_LSB +: 3]) :
         RESET_VECTOR[14:0];
      // registered copies so these outputs come from flip-flops
      state_next.secured = state_next.sec_last != SEC_OPEN;
      state_next.busy    = state_next.st == ST_ERASE;
   end

   ////////////////////////////////////////////////////////////////////////
   // state register

   // secure last byte starts open so a blank part is not locked
   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         state_reg          <= '0;
         state_reg.st       <= ST_IDLE;
         state_reg.ldcfg    <= CFG_RESET;
         state_reg.sec_last <= SEC_OPEN;
         state_reg.etgt     <= TGT_FLASH;
      end else begin
         state_reg <= state_next;
      end
   end

   // storage arrays have no reset, as real flash and ram would not
   always_ff @(posedge CLK) begin
      if (flash_we) begin
         flash_mem[flash_wa] <= flash_wd;
      end
      if (sec_we) begin
         sec_mem[sec_wa] <= sec_wd;
      end
      if (DMEM_REQ.valid && DMEM_REQ.write && DMEM_REQ.ext) begin
         extended_data_ram_mem[DMEM_REQ.addr] <= DMEM_REQ.wdata;
      end
      if (DMEM_REQ.valid && DMEM_REQ.write && !DMEM_REQ.ext) begin
         iram_mem[DMEM_REQ.addr[7:0]] <= DMEM_REQ.wdata;
      end
   end

   // outputs straight from the state flip-flops
   assign VECTOR_ADDR        = state_reg.vector;
   assign BOOT_BASE          = state_reg.base;
   assign BOOT_LOADER        = state_reg.boot_ldr;
   assign SECURED            = state_reg.secured;
   assign LOADER_SIZE_CONFIG = state_reg.ldcfg;
   assign FETCH_RSP          = state_reg.fetch;
   assign CODE_READ_RSP      = state_reg.cread;
   assign DMEM_RSP           = state_reg.dmem;
   assign CMD_RSP            = state_reg.cmd;
   assign CMD_BUSY           = state_reg.busy;

   ////////////////////////////////////////////////////////////////////////
   // assertions

   default clocking cb @(posedge CLK); endclocking
   default disable iff (!RST_N);

   a_vector_spacing: assert property (
      INT_TAKE |=> VECTOR_ADDR == 16'(16'h0003 + 16'h0008 * $past(INT_NUM)))
      else $error("interrupt vector not at 3 plus 8 per source");

   a_boot_base_map: assert property (
      state_reg.booted |-> BOOT_BASE == (BOOT_LOADER ?
         loader_start(LOADER_SIZE_CONFIG[2:0]) : 15'd0))
      else $error("boot base does not match boot region");

   a_boot_select: assert property (
      !state_reg.booted ##1 !$past(SW_RESET) |->
         BOOT_LOADER == (!$past(BOOT_REGION_SELECT) &&
                         $past(LOADER_SIZE_CONFIG[2:0]) != 3'b111))
      else $error("boot region does not follow boot select");

   a_concealed_read: assert property (
      CODE_READ_REQ.valid && in_secure(CODE_READ_REQ.addr) && SECURED &&
      !state_reg.exec_sec |=> CODE_READ_RSP.ack && CODE_READ_RSP.data == 8'h00)
      else $error("secured data read not concealed");

   a_debug_fetch: assert property (
      FETCH_REQ.valid && in_secure(FETCH_REQ.addr) && SECURED &&
      DEBUG_CONNECTED |=> FETCH_RSP.data == 8'h00)
      else $error("secured fetch visible to debug port");

   a_secure_refused: assert property (
      !CMD_BUSY && CMD_REQ.valid && CMD_REQ.target == TGT_SECURE &&
      CMD_REQ.op != OP_CHIP_ERASE && SECURED |=> CMD_RSP.done && CMD_RSP.fail
         && !CMD_BUSY)
      else $error("secured region command not refused");

   a_page_erase: assert property (
      !CMD_BUSY && CMD_REQ.valid && CMD_REQ.op == OP_ERASE &&
      CMD_REQ.target == TGT_FLASH && in_flash(CMD_REQ.addr) |=>
         CMD_BUSY[*8] ##[120:120] CMD_BUSY ##1 !CMD_BUSY && CMD_RSP.done)
      else $error("page erase not 128 cycles");

   a_chip_keeps_secure: assert property (
      CMD_BUSY && state_reg.etgt == TGT_CONFIG |-> !sec_we)
      else $error("whole-chip erase touched the secure region");

   a_config_reset: assert property (
      $rose(state_reg.booted) |-> $past(LOADER_SIZE_CONFIG) == 8'hff)
      else $error("config byte not all ones after reset");

   c_loader_boot: cover property (state_reg.booted && BOOT_LOADER);
   c_secured_read: cover property (SECURED && CODE_READ_RSP.ack);
   c_page_erase_done: cover property ($fell(CMD_BUSY));
   c_cmd_refused: cover property (CMD_RSP.fail);
endmodule : program_memory_map_protect

// ### sim/cpu_model.sv
// cpu core model issuing instruction fetches and code-memory data reads
`timescale 1ns/1ps
module cpu_model (
   input  wire pmem_pkg::rd_rsp_t fetch_rsp,
   input  wire pmem_pkg::rd_rsp_t code_read_rsp,
   input  wire logic              clk,
   output pmem_pkg::code_req_t    fetch_req,
   output pmem_pkg::code_req_t    code_read_req
);
   import pmem_pkg::*;

   initial begin
      fetch_req = '0;
      code_read_req = '0;
   end

   ////////////////////////////////////////////////////////////////////////
   // one byte read; the address is inverted once released so a stale
   // address can never look like a fresh request
   task automatic rd(input logic code, input logic [15:0] a,
                     output logic [7:0] d);
      @(posedge clk);
      if (code) code_read_req <= '{1'b1, a};
      else fetch_req <= '{1'b1, a};
      @(posedge clk);
      if (code) code_read_req <= '{1'b0, ~a};
      else fetch_req <= '{1'b0, ~a};
      #1;
      // ack stands one cycle only, so it is taken right here
      d = (code ? code_read_rsp.ack : fetch_rsp.ack) ?
          (code ? code_read_rsp.data : fetch_rsp.data) : 8'hxx;
   endtask : rd
endmodule : cpu_model

// ### sim/tb.sv
// self-checking bench for the program memory map and protection block
`timescale 1ns/1ps
module tb;
   import pmem_pkg::*;
   logic        clk = 1'b0;
   logic        rst_n = 1'b0;
   logic        boot_sel = 1'b1;
   logic        sw_reset = 1'b0;
   logic        sw_ldr = 1'b0;
   logic        dbg = 1'b0;
   logic        int_take = 1'b0;
   logic [4:0]  int_num = 5'h00;
   dmem_req_t   dmem_req = '0;
   cmd_req_t    cmd_req = '0;
   code_req_t   fetch_req, code_read_req;
   rd_rsp_t     fetch_rsp, code_read_rsp, dmem_rsp;
   cmd_rsp_t    cmd_rsp;
   logic [15:0] vec_addr;
   logic [14:0] boot_base;
   logic        boot_ldr, secured, busy, f;
   logic [7:0]  cfg, d;
   int          n_errors = 0, n_compared = 0, cycles = 0, nbusy;

   always #4 clk = ~clk;

   program_memory_map_protect u_program_memory_map_protect (
      .CLK(clk), .RST_N(rst_n), .BOOT_REGION_SELECT(boot_sel),
      .SW_RESET(sw_reset), .SW_BOOT_LOADER(sw_ldr),
      .DEBUG_CONNECTED(dbg), .INT_TAKE(int_take), .INT_NUM(int_num),
      .FETCH_REQ(fetch_req), .CODE_READ_REQ(code_read_req),
      .DMEM_REQ(dmem_req), .CMD_REQ(cmd_req), .VECTOR_ADDR(vec_addr),
      .BOOT_BASE(boot_base), .BOOT_LOADER(boot_ldr), .SECURED(secured),
      .LOADER_SIZE_CONFIG(cfg), .FETCH_RSP(fetch_rsp),
      .CODE_READ_RSP(code_read_rsp), .DMEM_RSP(dmem_rsp),
      .CMD_RSP(cmd_rsp), .CMD_BUSY(busy));

   cpu_model u_cpu_model (
      .fetch_rsp(fetch_rsp), .code_read_rsp(code_read_rsp), .clk(clk),
      .fetch_req(fetch_req), .code_read_req(code_read_req));

   ////////////////////////////////////////////////////////////////////////
   task automatic chk(input string nm, input logic [15:0] seen, exp);
      n_compared++;
      if (seen !== exp) begin
         n_errors++;
         $display("[ERR] %s expected %h seen %h", nm, exp, seen);
      end
   endtask : chk

   task automatic wrap_up;
      if (n_errors == 0 && n_compared > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask : wrap_up

   // one flash command; counts busy cycles while waiting for done
   task automatic cmd(input cmd_op_t op, input target_t tg, input logic in_system_programming,
                      input logic [15:0] a, input logic [7:0] w);
      int n;
      n = 0;
      nbusy = 0;
      @(posedge clk);
      cmd_req <= '{1'b1, op, tg, in_system_programming, a, w};
      @(posedge clk);
      cmd_req.valid <= 1'b0;
      #1;
      while (cmd_rsp.done !== 1'b1 && n < 20000) begin
         nbusy += int'(busy);
         n++;
         @(posedge clk);
         #1;
      end
      f = cmd_rsp.fail;
      d = cmd_rsp.rdata;
   endtask : cmd

   task automatic dm(input logic wr, ext, input logic [9:0] a,
                     input logic [7:0] w);
      @(posedge clk);
      dmem_req <= '{1'b1, wr, ext, a, w};
      @(posedge clk);
      dmem_req.valid <= 1'b0;
      #1;
      d = dmem_rsp.data;
   endtask : dm

   ////////////////////////////////////////////////////////////////////////
   // hang guard: chip erase alone needs some 16400 cycles
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 25000) begin
         n_errors++;
         wrap_up;
      end
   end

   initial begin
      repeat (3) @(posedge clk);
      rst_n <= 1'b1;
      repeat (2) @(posedge clk);
      #1;
      chk("cfg", {8'h00, cfg}, 16'h00ff);
      chk("boot_ldr", {15'h0000, boot_ldr}, 16'h0000);
      chk("boot_base", {1'b0, boot_base}, 16'h0000);
      for (int i = 0; i < 4; i++) begin
         @(posedge clk);
         int_take <= 1'b1;
         int_num <= 5'(i);
         @(posedge clk);
         int_take <= 1'b0;
         #1;
         chk("vector", vec_addr, 16'(3 + 8 * i));
      end
      cmd(OP_ERASE, TGT_FLASH, 1'b0, 16'h0105, 8'h00);
      chk("erase_busy", 16'(nbusy), 16'd128);
      cmd(OP_READ, TGT_FLASH, 1'b0, 16'h017f, 8'h00);
      chk("erased", {7'h00, f, d}, 16'h00ff);
      cmd(OP_PROGRAM, TGT_FLASH, 1'b0, 16'h0100, 8'ha5);
      cmd(OP_READ, TGT_FLASH, 1'b0, 16'h0100, 8'h00);
      chk("prog_read", {7'h00, f, d}, 16'h00a5);
      u_cpu_model.rd(1'b0, 16'h0100, d);
      chk("fetch", {8'h00, d}, 16'h00a5);
      u_cpu_model.rd(1'b1, 16'h0100, d);
      chk("movc", {8'h00, d}, 16'h00a5);
      // same offset in both rams must stay apart
      dm(1'b1, 1'b0, 10'h010, 8'h3c);
      dm(1'b1, 1'b1, 10'h010, 8'hc3);
      dm(1'b0, 1'b0, 10'h010, 8'h00);
      chk("iram", {8'h00, d}, 16'h003c);
      dm(1'b0, 1'b1, 10'h010, 8'h00);
      chk("extended_data_ram", {8'h00, d}, 16'h00c3);
      cmd(OP_ERASE, TGT_SECURE, 1'b1, 16'h0000, 8'h00);
      cmd(OP_PROGRAM, TGT_SECURE, 1'b1, 16'h0000, 8'h11);
      cmd(OP_READ, TGT_SECURE, 1'b1, 16'h0000, 8'h00);
      chk("sec_open", {7'h00, f, d}, 16'h0011);
      cmd(OP_PROGRAM, TGT_SECURE, 1'b1, 16'h007f, 8'h00);
      @(posedge clk);
      #1;
      chk("secured", {15'h0000, secured}, 16'h0001);
      u_cpu_model.rd(1'b1, 16'hff80, d);
      chk("conceal", {8'h00, d}, 16'h0000);
      @(posedge clk);
      dbg <= 1'b1;
      u_cpu_model.rd(1'b0, 16'hff80, d);
      chk("dbg_fetch", {8'h00, d}, 16'h0000);
      @(posedge clk);
      dbg <= 1'b0;
      u_cpu_model.rd(1'b0, 16'hff80, d);
      chk("sec_fetch", {8'h00, d}, 16'h0011);
      u_cpu_model.rd(1'b1, 16'hff80, d);
      chk("sec_movc", {8'h00, d}, 16'h0011);
      cmd(OP_READ, TGT_SECURE, 1'b1, 16'h0000, 8'h00);
      chk("isp_read", {15'h0000, f}, 16'h0001);
      cmd(OP_ERASE, TGT_SECURE, 1'b1, 16'h0000, 8'h00);
      chk("isp_erase", {15'h0000, f}, 16'h0001);
      cmd(OP_CHIP_ERASE, TGT_FLASH, 1'b1, 16'h0000, 8'h00);
      chk("chip_keep", {15'h0000, secured}, 16'h0001);
      // 1K loader sits at the top of the 16K flash
      cmd(OP_PROGRAM, TGT_CONFIG, 1'b1, 16'h0000, 8'hfe);
      chk("cfg_size", {8'h00, cfg}, 16'h00fe);
      cmd(OP_PROGRAM, TGT_FLASH, 1'b1, 16'h3c00, 8'h77);
      @(posedge clk);
      sw_ldr <= 1'b1;
      sw_reset <= 1'b1;
      @(posedge clk);
      sw_reset <= 1'b0;
      repeat (2) @(posedge clk);
      #1;
      chk("ldr_boot", {15'h0000, boot_ldr}, 16'h0001);
      chk("ldr_base", {1'b0, boot_base}, 16'h3c00);
      u_cpu_model.rd(1'b0, 16'h0000, d);
      chk("ldr_fetch", {8'h00, d}, 16'h0077);
      wrap_up;
   end
endmodule : tb
